// ### verilog/flm_pkg.sv
`default_nettype none
package flm_pkg;

    // Number of latency pulses in one measurement window.
    localparam int unsigned NUM_PULSES = 128;
    localparam int unsigned PULSE_CNT_W = 16;
    localparam int unsigned TOTAL_W = 32;
    localparam int unsigned NUM_FIFOS = 4;
    localparam int unsigned SCLK_MAX_MHZ = 260;
    localparam int unsigned MCLK_MHZ = 100;

    localparam logic [PULSE_CNT_W-1:0] PULSE_TARGET = PULSE_CNT_W'(NUM_PULSES);
    localparam logic [PULSE_CNT_W-1:0] PULSE_ZERO = {PULSE_CNT_W{1'b0}};
    localparam logic [TOTAL_W-1:0] TOTAL_ZERO = {TOTAL_W{1'b0}};
    localparam logic [TOTAL_W-1:0] TOTAL_ONE = {{(TOTAL_W-1){1'b0}}, 1'b1};
    localparam logic [PULSE_CNT_W-1:0] PULSE_ONE = {{(PULSE_CNT_W-1){1'b0}}, 1'b1};

    typedef enum logic [2:0] {
        FLM_IDLE = 3'b001,
        FLM_RUN = 3'b010,
        FLM_DONE = 3'b100
    } flm_state_e;

    typedef struct packed {
        logic [TOTAL_W-1:0] totalCount;
        logic resultReady;
    } flm_result_s;

endpackage
`default_nettype wire

// ### verilog/flm_channel.sv
`default_nettype none
// Function
// - Sample every rising mclk edge with clkEn high, count the ones
// - Latency is averaged over a window
// - Window is NUM_PULSES pulses, default 128
// - Start request begins a calculation
// - Done flag marks total valid
// - Latency equals total times period over pulses
// - One independent instance per FIFO, four
// - Sampling clock at most 260 MHz
// - Sampling clock differs from parallel clock
// - Ratio denominator at least 50
// - Sampling clock not multiple of tx clock
module flm_channel
(
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic clkEn,
    input wire logic startCalc,
    input wire logic latencyPulse,
    output var flm_pkg::flm_result_s result
);

    flm_pkg::flm_state_e state_q;
    logic [flm_pkg::PULSE_CNT_W-1:0] pulseCnt_q;
    logic [flm_pkg::TOTAL_W-1:0] total_q;
    logic ready_q;
    logic pulsePrev_q;
    logic pulseRise;
    logic startPrev_q;
    logic startRise;

    // The pulse is already hardened into this domain by the device.
    assign pulseRise = latencyPulse && !pulsePrev_q;
    assign startRise = startCalc && !startPrev_q;

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pulsePrev_q <= 1'b0;
            startPrev_q <= 1'b0;
        end
        else if (clkEn)
        begin
            pulsePrev_q <= latencyPulse;
            startPrev_q <= startCalc;
        end
    end

    // A start edge is checked before the window end, so a restart that lands on the
    // closing pulse edge leaves the channel running, never done with a stale total.
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            state_q <= flm_pkg::FLM_IDLE;
        else if (clkEn)
        begin
            unique case (state_q)
                flm_pkg::FLM_IDLE, flm_pkg::FLM_DONE:
                    if (startRise)
                        state_q <= flm_pkg::FLM_RUN;
                flm_pkg::FLM_RUN:
                    if (startRise)
                        state_q <= flm_pkg::FLM_RUN;
                    else if (pulseRise && pulseCnt_q == flm_pkg::PULSE_TARGET)
                        state_q <= flm_pkg::FLM_DONE;
                default:
                    state_q <= flm_pkg::FLM_IDLE;
            endcase
        end
    end

    // Counts rising edges; the window closes at the edge that starts pulse
    // NUM_PULSES + 1, so exactly NUM_PULSES whole pulses are measured.
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            pulseCnt_q <= flm_pkg::PULSE_ZERO;
        else if (clkEn)
        begin
            if (startRise)
                pulseCnt_q <= flm_pkg::PULSE_ZERO;
            else if (state_q == flm_pkg::FLM_RUN && pulseRise)
                pulseCnt_q <= pulseCnt_q + flm_pkg::PULSE_ONE;
        end
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            total_q <= flm_pkg::TOTAL_ZERO;
        else if (clkEn)
        begin
            if (startRise)
                total_q <= flm_pkg::TOTAL_ZERO;
            // The sample on the first rising edge belongs to pulse one and is counted;
            // samples before it, and the one that opens the extra pulse, are not.
            else if (state_q == flm_pkg::FLM_RUN && latencyPulse
                     && (pulseCnt_q != flm_pkg::PULSE_ZERO || pulseRise)
                     && !(pulseRise && pulseCnt_q == flm_pkg::PULSE_TARGET))
                total_q <= total_q + flm_pkg::TOTAL_ONE;
        end
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            ready_q <= 1'b0;
        else if (clkEn)
        begin
            if (startRise)
                ready_q <= 1'b0;
            else if (state_q == flm_pkg::FLM_RUN && pulseRise
                     && pulseCnt_q == flm_pkg::PULSE_TARGET)
                ready_q <= 1'b1;
        end
    end

    // Latency in ns is totalCount times the mclk period over NUM_PULSES.
    assign result.totalCount = total_q;
    assign result.resultReady = ready_q;

    // The integrator chooses mclk; no logic here can check it.
    // It stays at or below SCLK_MAX_MHZ and off the parallel clock.
    // Its ratio to the parallel clock has a large denominator.
    // It is never an integer multiple of the transmit clock.

    clearOnStart_a: assert property (@(posedge mclk) disable iff (!arst_n)
        clkEn && startRise |=> !ready_q && total_q == flm_pkg::TOTAL_ZERO)
        else $error("start did not clear result");
    clearCount_a: assert property (@(posedge mclk) disable iff (!arst_n)
        clkEn && startRise |=> pulseCnt_q == flm_pkg::PULSE_ZERO)
        else $error("start did not clear pulse count");
    readyHold_a: assert property (@(posedge mclk) disable iff (!arst_n)
        ready_q && !(clkEn && startRise) |=> ready_q && $stable(total_q))
        else $error("result changed before next start");
    idleQuiet_a: assert property (@(posedge mclk) disable iff (!arst_n)
        state_q != flm_pkg::FLM_RUN && !(clkEn && startRise) |=> $stable(total_q))
        else $error("total moved outside a run");
    readyCause_a: assert property (@(posedge mclk) disable iff (!arst_n)
        $rose(ready_q) |-> $past(pulseCnt_q) == flm_pkg::PULSE_TARGET)
        else $error("done without full window");
    doneCount_a: assert property (@(posedge mclk) disable iff (!arst_n)
        state_q == flm_pkg::FLM_DONE |-> pulseCnt_q == flm_pkg::PULSE_TARGET + flm_pkg::PULSE_ONE)
        else $error("done state with wrong pulse count");
    countOnes_a: assert property (@(posedge mclk) disable iff (!arst_n)
        total_q != $past(total_q) && !$past(startRise) |-> $past(latencyPulse))
        else $error("total grew on zero sample");
    // The opening sample of pulse one must reach the total.
    firstSample_a: assert property (@(posedge mclk) disable iff (!arst_n)
        clkEn && state_q == flm_pkg::FLM_RUN && !startRise && pulseRise
        && pulseCnt_q == flm_pkg::PULSE_ZERO |=> total_q == flm_pkg::TOTAL_ONE)
        else $error("first sample of window lost");
    runOnStart_a: assert property (@(posedge mclk) disable iff (!arst_n)
        clkEn && startRise |=> state_q == flm_pkg::FLM_RUN)
        else $error("start did not begin run");
    doneState_a: assert property (@(posedge mclk) disable iff (!arst_n)
        ready_q |-> state_q == flm_pkg::FLM_DONE)
        else $error("flag without done state");
    runNoFlag_a: assert property (@(posedge mclk) disable iff (!arst_n)
        state_q == flm_pkg::FLM_RUN |-> !ready_q)
        else $error("flag raised during a run");
    totalBound_a: assert property (@(posedge mclk) disable iff (!arst_n)
        state_q == flm_pkg::FLM_IDLE |-> total_q == flm_pkg::TOTAL_ZERO)
        else $error("total nonzero when idle");
    cntBound_a: assert property (@(posedge mclk) disable iff (!arst_n)
        state_q == flm_pkg::FLM_RUN |-> pulseCnt_q <= flm_pkg::PULSE_TARGET)
        else $error("pulse count ran past window");
    pulseStep_a: assert property (@(posedge mclk) disable iff (!arst_n)
        pulseCnt_q != $past(pulseCnt_q) && !$past(startRise) |-> $past(pulseRise))
        else $error("pulse count moved without a pulse edge");
    freeze_a: assert property (@(posedge mclk) disable iff (!arst_n)
        !clkEn |=> $stable(total_q) && $stable(pulseCnt_q))
        else $error("state moved with enable low");

    runCov_c: cover property (@(posedge mclk) disable iff (!arst_n) $rose(ready_q));
    restartCov_c: cover property (@(posedge mclk) disable iff (!arst_n)
        state_q == flm_pkg::FLM_RUN && startRise);
    againCov_c: cover property (@(posedge mclk) disable iff (!arst_n)
        ready_q && startRise);
    freezeCov_c: cover property (@(posedge mclk) disable iff (!arst_n)
        state_q == flm_pkg::FLM_RUN && !clkEn);
    startHighCov_c: cover property (@(posedge mclk) disable iff (!arst_n)
        clkEn && startRise && latencyPulse);

endmodule
`default_nettype wire

// ### verilog/flm_top.sv
`default_nettype none
// Four independent channels, one per FIFO latency pulse.
module flm_top
(
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic clkEn,
    input wire logic [flm_pkg::NUM_FIFOS-1:0] startCalc,
    input wire logic [flm_pkg::NUM_FIFOS-1:0] latencyPulse,
    output wire flm_pkg::flm_result_s [flm_pkg::NUM_FIFOS-1:0] results
);

    genvar i;
    generate
        for (i = 0; i < flm_pkg::NUM_FIFOS; i++)
        begin : g_ch
            flm_channel u_ch
            (
                .mclk(mclk),
                .arst_n(arst_n),
                .clkEn(clkEn),
                .startCalc(startCalc[i]),
                .latencyPulse(latencyPulse[i]),
                .result(results[i])
            );
        end
    endgenerate

endmodule
`default_nettype wire

// ### dv/flm_pulse_model.sv
`default_nettype none
// Stands in for the transceiver: one latency pulse per FIFO, depth 8.
module flm_pulse_model
(
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic [15:0] highCnt,
    output logic [3:0] latencyPulse
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] phase_q;
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            phase_q <= 3'h0;
        else
            phase_q <= phase_q + 3'h1;
    end
    // High for fill words of every 8 cycles, already in the mclk domain.
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            latencyPulse <= 4'h0;
        else
            for (int i = 0; i < 4; i++)
                latencyPulse[i] <= ({1'b0, phase_q} < highCnt[i*4+:4]);
    end
endmodule
`default_nettype wire

// ### dv/flm_top_bench.sv
`default_nettype none
module flm_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic clkEn = 1'b1;
    logic [3:0] startCalc = 4'h0;
    logic [15:0] highCnt = 16'h4321;
    logic [3:0] latencyPulse;
    logic [3:0] rdy;
    flm_pkg::flm_result_s [3:0] results;
    int failures = 0;
    int check_count = 0;
    always #5 mclk = ~mclk;
    always_comb
        for (int i = 0; i < 4; i++)
            rdy[i] = results[i].resultReady;
    flm_top u_flm_top (.mclk(mclk), .arst_n(arst_n), .clkEn(clkEn), .startCalc(startCalc),
        .latencyPulse(latencyPulse), .results(results));
    flm_pulse_model u_flm_pulse_model (.mclk(mclk), .arst_n(arst_n), .highCnt(highCnt),
        .latencyPulse(latencyPulse));
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            failures++;
            $display("[ERR] %s expected %0h seen %0h", name, exp, seen);
        end
    endtask
    task automatic complete_run;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic kick(input logic [3:0] m);
        @(posedge mclk);
        startCalc <= m;
        @(posedge mclk);
        startCalc <= 4'h0;
    endtask
    task automatic await(input logic [3:0] m);
        int n;
        for (n = 0; n < 3000 && (rdy & m) !== m; n++)
            @(posedge mclk);
        chk("ready", 32'(n < 3000), 32'h1);
    endtask
    task automatic t_all;
        kick(4'hF);
        await(4'hF);
        for (int i = 0; i < 4; i++)
        begin
            chk("total", results[i].totalCount, 32'h80 * highCnt[i*4+:4]);
            chk("ns", results[i].totalCount * 10 / 128, 10 * highCnt[i*4+:4]);
        end
    endtask
    task automatic t_hold;
        repeat (60) @(posedge mclk);
        chk("hold", results[2].totalCount, 32'h80 * highCnt[11:8]);
        chk("holdRdy", 32'(rdy[2]), 32'h1);
    endtask
    task automatic t_restart;
        highCnt <= 16'h7156;
        kick(4'h1);
        @(posedge mclk);
        chk("clr", results[0].totalCount, 32'h0);
        chk("clrRdy", 32'(rdy[0]), 32'h0);
        repeat (300) @(posedge mclk);
        kick(4'h1);
        await(4'h1);
        chk("restart", results[0].totalCount, 32'h300);
        chk("others", rdy[3:1], 3'h7);
        chk("othersTot", results[3].totalCount, 32'h200);
    endtask
    task automatic t_freeze;
        logic [31:0] t;
        kick(4'h2);
        repeat (200) @(posedge mclk);
        clkEn <= 1'b0;
        @(posedge mclk);
        t = results[1].totalCount;
        repeat (63) @(posedge mclk);
        chk("frozen", results[1].totalCount, t);
        clkEn <= 1'b1;
        await(4'h2);
        chk("thawed", results[1].totalCount, 32'h80 * highCnt[7:4]);
    endtask
    initial
    begin
        repeat (5) @(posedge mclk);
        arst_n <= 1'b1;
        @(posedge mclk);
        t_all();
        t_hold();
        t_restart();
        t_freeze();
        complete_run();
    end
    initial
    begin
        #100000;
        failures++;
        complete_run();
    end
endmodule
`default_nettype wire
